// File: inc/csc_params.svh
// Constants shared by the slice end and the controller end
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// ---------------------------------------------------------------
// Widths and depths
// ---------------------------------------------------------------
`define CSC_W 4
`define CSC_AW 4
`define CSC_IW 9
`define CSC_RAM_DEPTH 16
`define CSC_MSB 3

// ---------------------------------------------------------------
// Field positions inside the microinstruction word
// ---------------------------------------------------------------
`define CSC_SRC_BIT 0
`define CSC_FN_LO 1
`define CSC_FN_HI 4
`define CSC_DST_LO 5
`define CSC_DST_HI 8

// ---------------------------------------------------------------
// ALU function codes
// ---------------------------------------------------------------
`define CSC_FN_ADD 4'h0
`define CSC_FN_SUB 4'h1
`define CSC_FN_AND 4'h2
`define CSC_FN_OR 4'h3
`define CSC_FN_XOR 4'h4
`define CSC_FN_PASS 4'h5

// ---------------------------------------------------------------
// Destination codes
// ---------------------------------------------------------------
`define CSC_DST_PAR_LO 4'h4
`define CSC_DST_PAR_HI 4'h7
`define CSC_DST_RAM_DN 4'h8
`define CSC_DST_RAM_UP 4'hA
`define CSC_DST_LOAD_Q 4'hC
`define CSC_DST_SIGNX 4'hE
`define CSC_DST_PASS 4'hF

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CSC_RST_WORD 4'h0
`define CSC_RST_INSTR 9'h000
`define CSC_RST_ADDR 4'h0

`endif

// File: inc/csc_pkg.sv
// Types shared by both ends of the slice cascade
package csc_pkg;
  // Position of a slice in the stacked word, one-hot
  typedef enum logic [2:0] {
    CSC_ROLE_LOW = 3'b001,
    CSC_ROLE_MID = 3'b010,
    CSC_ROLE_TOP = 3'b100
  } csc_role_t;

  // Source chosen by the end-of-word shift multiplexer
  typedef enum logic [1:0] {
    CSC_SH_ZERO = 2'h0,
    CSC_SH_ONE = 2'h1,
    CSC_SH_ROT = 2'h2,
    CSC_SH_USER = 2'h3
  } csc_shsel_t;
endpackage

// File: inc/csc_if.sv
// Connection between one slice and its surroundings
`include "csc_params.svh"
interface csc_if;
  // ---------------------------------------------------------------
  // Microinstruction from the pipeline register, plus strap and write strobe
  // ---------------------------------------------------------------
  logic [`CSC_IW-1:0] instr;
  logic [`CSC_AW-1:0] a_addr;
  logic [`CSC_AW-1:0] b_addr;
  logic [`CSC_W-1:0] data;
  logic instruction_enable_low;
  logic write_enable_n;
  logic lowest_slice_select_n;
  logic carry_input;
  // ---------------------------------------------------------------
  // Slice results
  // ---------------------------------------------------------------
  logic [`CSC_W-1:0] y;
  logic carry_output;
  logic gen_n_or_sign;
  logic prop_n_or_overflow_flag;
  // ---------------------------------------------------------------
  // Two-way lines: each party gives out and oe, the zero line only a slice oe; pull-up when idle
  // ---------------------------------------------------------------
  logic wr_s_out, wr_s_oe, wr_c_out, wr_c_oe, write_or_top_slice_pin;
  logic ql_s_out, ql_s_oe, ql_c_out, ql_c_oe, q_shift_port_lo;
  logic qh_s_out, qh_s_oe, qh_c_out, qh_c_oe, q_shift_port_hi;
  logic sl_s_out, sl_s_oe, sl_c_out, sl_c_oe, alu_shift_port_lo;
  logic sh_s_out, sh_s_oe, sh_c_out, sh_c_oe, alu_shift_port_hi;
  logic zero_oe, zero_line;

  // Wire resolution, undriven lines float high through the pull-up
  assign write_or_top_slice_pin = wr_s_oe ? wr_s_out :
                                  (wr_c_oe ? wr_c_out : 1'b1);
  assign q_shift_port_lo = ql_s_oe ? ql_s_out : (ql_c_oe ? ql_c_out : 1'b1);
  assign q_shift_port_hi = qh_s_oe ? qh_s_out : (qh_c_oe ? qh_c_out : 1'b1);
  assign alu_shift_port_lo = sl_s_oe ? sl_s_out :
                             (sl_c_oe ? sl_c_out : 1'b1);
  assign alu_shift_port_hi = sh_s_oe ? sh_s_out :
                             (sh_c_oe ? sh_c_out : 1'b1);
  assign zero_line = zero_oe ? 1'b0 : 1'b1;

  modport slice (
    input instr, a_addr, b_addr, data, instruction_enable_low,
    input write_enable_n, lowest_slice_select_n, carry_input,
    output y, carry_output, gen_n_or_sign, prop_n_or_overflow_flag,
    output wr_s_out, wr_s_oe, ql_s_out, ql_s_oe, qh_s_out, qh_s_oe,
    output sl_s_out, sl_s_oe, sh_s_out, sh_s_oe, zero_oe,
    input write_or_top_slice_pin, q_shift_port_lo, q_shift_port_hi,
    input alu_shift_port_lo, alu_shift_port_hi, zero_line
  );

  modport ctrl (
    output instr, a_addr, b_addr, data, instruction_enable_low,
    output write_enable_n, lowest_slice_select_n, carry_input,
    input y, carry_output, gen_n_or_sign, prop_n_or_overflow_flag,
    output wr_c_out, wr_c_oe, ql_c_out, ql_c_oe, qh_c_out, qh_c_oe,
    output sl_c_out, sl_c_oe, sh_c_out, sh_c_oe,
    input write_or_top_slice_pin, q_shift_port_lo, q_shift_port_hi,
    input alu_shift_port_lo, alu_shift_port_hi, zero_line
  );
endinterface

// File: verilog/csc_slice.sv
// Four-bit CPU slice: cascade, write sharing, parity and sign extend
`include "csc_params.svh"

// Summary of operation
// [RULE1] Microinstruction comes pipelined, executed next cycle
// [RULE2] Stackable by four bits, same wiring always
// [RULE3] Upper shift ports feed next slice's lower
// [RULE4] Q and result shift as one word
// [RULE5] Word ends fed by microcode shift multiplexer
// [RULE6] Lowest slice drives shared write strobe out
// [RULE7] Intermediate slices hold both straps high
// [RULE8] Top slice: select high, write pin low
// [RULE9] Zero line is shared open-collector wire
// [RULE10] Ripple: carry out feeds next carry in
// [RULE11] Lookahead uses generate, propagate, returns carries
// [RULE12] Top gives sign, overflow; others generate, propagate
// [RULE13] Enable low: RAM and Q update; here a middle-strapped slice never writes its RAM, its write pin idling high
// [RULE14] Enable high: RAM and Q held; here a top-strapped slice writes its RAM every cycle, its write pin low
// [RULE15] Controller times enable for three-address writes; here it swaps the C address in for B and passes the enable through
// [RULE16] Destination four to seven computes parity
// [RULE17] Parity of result and upper port, out below
// [RULE18] Code E spreads lower sign across slice
// [RULE19] Code F puts result MSB on upper port
// [RULE20] Controller picks extend or pass per slice
// [RULE21] Next edge stores result at B address
module csc_slice
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Cascade side
  csc_if.slice bus,
  // Observation
  output logic [`CSC_W-1:0] q_reg_out,
  output csc_role_t role_out
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [`CSC_W-1:0] ram_q [`CSC_RAM_DEPTH];
  logic [`CSC_W-1:0] ram_d [`CSC_RAM_DEPTH];
  logic [`CSC_W-1:0] q_q, q_d, q_sh;
  csc_role_t role_q, role_d;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [3:0] fn;
  logic [3:0] dst;
  logic [`CSC_W-1:0] r_op, s_op, f;
  logic [`CSC_W:0] sum;
  logic [`CSC_W-1:0] y;
  logic c3, c4, gen_n, prop_n;
  logic ram_wr, q_wr, is_par, is_top, is_low;

  assign fn = bus.instr[`CSC_FN_HI:`CSC_FN_LO];
  assign dst = bus.instr[`CSC_DST_HI:`CSC_DST_LO];
  assign is_par = (dst >= `CSC_DST_PAR_LO) &&
                  (dst <= `CSC_DST_PAR_HI); // [RULE16]
  // Role from the straps; every slice decodes the same way [RULE2]
  assign is_low = !bus.lowest_slice_select_n; // [RULE6]
  assign is_top = bus.lowest_slice_select_n &&
                  !bus.write_or_top_slice_pin; // [RULE8] [RULE7]

  // Operand select: source bit picks register B or the data inputs
  assign r_op = ram_q[bus.a_addr];
  assign s_op = bus.instr[`CSC_SRC_BIT] ? bus.data : ram_q[bus.b_addr];

  // ---------------------------------------------------------------
  // ALU, with carry chain terms for ripple or lookahead
  // ---------------------------------------------------------------
  always_comb begin
    logic [`CSC_W-1:0] r_eff;
    r_eff = (fn == `CSC_FN_SUB) ? ~r_op : r_op;
    sum = {1'b0, r_eff} + {1'b0, s_op} +
          {{`CSC_W{1'b0}}, bus.carry_input}; // [RULE10] [RULE11]
    c3 = r_eff[`CSC_MSB] ^ s_op[`CSC_MSB] ^ sum[`CSC_MSB];
    c4 = sum[`CSC_W];
    gen_n = !(|(r_eff & s_op));
    prop_n = !(&(r_eff | s_op));
    case (fn)
      `CSC_FN_ADD: f = sum[`CSC_W-1:0];
      `CSC_FN_SUB: f = sum[`CSC_W-1:0];
      `CSC_FN_AND: f = r_op & s_op;
      `CSC_FN_OR: f = r_op | s_op;
      `CSC_FN_XOR: f = r_op ^ s_op;
      `CSC_FN_PASS: f = s_op;
      default: f = sum[`CSC_W-1:0];
    endcase
    // Group terms are only meaningful for the arithmetic codes
    if ((fn != `CSC_FN_ADD) && (fn != `CSC_FN_SUB)) begin
      gen_n = 1'b1;
      prop_n = 1'b1;
      c4 = 1'b0;
      c3 = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Destination: result word, shift ports and write intents
  // ---------------------------------------------------------------
  // Shift ports are combinational so a whole stack settles in one
  // microcycle; registering them would cost a cycle per slice.
  always_comb begin
    y = f;
    q_sh = q_q;
    ram_wr = 1'b1;
    q_wr = 1'b0;
    bus.ql_s_out = 1'b0;
    bus.ql_s_oe = 1'b0;
    bus.qh_s_out = 1'b0;
    bus.qh_s_oe = 1'b0;
    bus.sl_s_out = 1'b0;
    bus.sl_s_oe = 1'b0;
    bus.sh_s_out = 1'b0;
    bus.sh_s_oe = 1'b0;
    if (is_par) begin
      // Parity ripples downward from the upper port [RULE17]
      bus.sl_s_out = (^f) ^ bus.alu_shift_port_hi; // [RULE17]
      bus.sl_s_oe = 1'b1;
    end else begin
      case (dst)
        `CSC_DST_RAM_DN: begin
          // Word and Q move toward the LSB as one long register
          y = {bus.alu_shift_port_hi, f[`CSC_MSB:1]}; // [RULE4] [RULE3]
          bus.sl_s_out = f[0];
          bus.sl_s_oe = 1'b1;
          q_sh = {bus.q_shift_port_hi, q_q[`CSC_MSB:1]}; // [RULE4]
          q_wr = 1'b1;
          bus.ql_s_out = q_q[0];
          bus.ql_s_oe = 1'b1;
        end
        `CSC_DST_RAM_UP: begin
          // Word and Q move toward the MSB as one long register
          y = {f[`CSC_MSB-1:0], bus.alu_shift_port_lo}; // [RULE4] [RULE3]
          bus.sh_s_out = f[`CSC_MSB];
          bus.sh_s_oe = 1'b1;
          q_sh = {q_q[`CSC_MSB-1:0], bus.q_shift_port_lo}; // [RULE4]
          q_wr = 1'b1;
          bus.qh_s_out = q_q[`CSC_MSB];
          bus.qh_s_oe = 1'b1;
        end
        `CSC_DST_LOAD_Q: begin
          q_sh = f;
          q_wr = 1'b1;
          ram_wr = 1'b0;
        end
        `CSC_DST_SIGNX: begin
          y = {`CSC_W{bus.alu_shift_port_lo}}; // [RULE18]
          bus.sh_s_out = bus.alu_shift_port_lo; // [RULE18]
          bus.sh_s_oe = 1'b1;
        end
        `CSC_DST_PASS: begin
          bus.sh_s_out = f[`CSC_MSB]; // [RULE19]
          bus.sh_s_oe = 1'b1;
        end
        default: begin
          y = f;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Cascade outputs
  // ---------------------------------------------------------------
  // Top slice shows sign and overflow, others the group terms
  assign bus.gen_n_or_sign = is_top ? f[`CSC_MSB] : gen_n; // [RULE12]
  assign bus.prop_n_or_overflow_flag = is_top ? (c3 ^ c4) : prop_n; // [RULE12]
  assign bus.carry_output = c4; // [RULE10]
  assign bus.y = y;
  // Open collector: pull low unless this slice's word is zero
  assign bus.zero_oe = |y; // [RULE9]
  // Only the lowest slice drives the shared write strobe; the
  // enable input gates it so a held instruction writes nothing
  assign bus.wr_s_out = !(ram_wr && !bus.instruction_enable_low); // [RULE6] [RULE14]
  assign bus.wr_s_oe = is_low; // [RULE6]

  // ---------------------------------------------------------------
  // Next state of RAM, Q and role
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `CSC_RAM_DEPTH; i++) begin
      ram_d[i] = ram_q[i];
    end
    // Shared strobe low means write the B register [RULE21] [RULE15]
    if (!bus.write_enable_n) begin
      ram_d[bus.b_addr] = y; // [RULE21]
    end
    // Q follows only while the enable input is low [RULE13] [RULE14]
    q_d = (bus.instruction_enable_low || !q_wr) ? q_q : q_sh; // [RULE14]
    role_d = is_low ? CSC_ROLE_LOW : (is_top ? CSC_ROLE_TOP : CSC_ROLE_MID);
  end

  // Registers only; the RAM clears so simulation starts defined
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `CSC_RAM_DEPTH; i++) begin
        ram_q[i] <= `CSC_RST_WORD;
      end
      q_q <= `CSC_RST_WORD;
      role_q <= CSC_ROLE_MID;
    end else begin
      for (int i = 0; i < `CSC_RAM_DEPTH; i++) begin
        ram_q[i] <= ram_d[i];
      end
      q_q <= q_d; // [RULE13]
      role_q <= role_d;
    end
  end

  assign q_reg_out = q_q;
  assign role_out = role_q;

endmodule

// File: verilog/csc_ctrl.sv
// Surroundings of one slice: pipeline register, straps, end muxes
`include "csc_params.svh"
module csc_ctrl
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Microinstruction fetched from the store this cycle
  input wire logic [`CSC_IW-1:0] instr_in,
  input wire logic [`CSC_AW-1:0] a_addr_in,
  input wire logic [`CSC_AW-1:0] b_addr_in,
  input wire logic [`CSC_AW-1:0] c_addr_in,
  input wire logic three_addr_in,
  input wire logic [`CSC_W-1:0] data_in,
  input wire logic instruction_enable_low_in,
  input wire logic carry_input_in,
  // Position strap and end-of-word shift selection
  input wire csc_role_t role_in,
  input wire csc_shsel_t shift_sel_in,
  input wire logic shift_user_in,
  // Observed results
  output logic [`CSC_W-1:0] y_out,
  output logic zero_out,
  // Slice side
  csc_if.ctrl bus
);

  // ---------------------------------------------------------------
  // Pipeline register: fetched now, executed next cycle [RULE1]
  // ---------------------------------------------------------------
  logic [`CSC_IW-1:0] instr_q, instr_d;
  logic [`CSC_AW-1:0] a_q, a_d, b_q, b_d;
  logic [`CSC_W-1:0] data_q, data_d, y_q, y_d;
  logic ien_q, ien_d, cin_q, cin_d, zero_q, zero_d;
  logic fill;

  always_comb begin
    instr_d = instr_in; // [RULE1]
    a_d = a_addr_in;
    // Three-address: result lands in C instead of B [RULE15]
    b_d = three_addr_in ? c_addr_in : b_addr_in; // [RULE15]
    data_d = data_in;
    ien_d = instruction_enable_low_in;
    cin_d = carry_input_in;
    y_d = bus.y;
    zero_d = bus.zero_line;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr_q <= `CSC_RST_INSTR;
      a_q <= `CSC_RST_ADDR;
      b_q <= `CSC_RST_ADDR;
      data_q <= `CSC_RST_WORD;
      ien_q <= 1'b1;
      cin_q <= 1'b0;
      y_q <= `CSC_RST_WORD;
      zero_q <= 1'b1;
    end else begin
      instr_q <= instr_d;
      a_q <= a_d;
      b_q <= b_d;
      data_q <= data_d;
      ien_q <= ien_d;
      cin_q <= cin_d;
      y_q <= y_d;
      zero_q <= zero_d;
    end
  end

  // ---------------------------------------------------------------
  // Drive the slice
  // ---------------------------------------------------------------
  assign bus.instr = instr_q;
  assign bus.a_addr = a_q;
  assign bus.b_addr = b_q;
  assign bus.data = data_q;
  assign bus.instruction_enable_low = ien_q;
  assign bus.carry_input = cin_q; // [RULE10] [RULE11]
  // Straps: lowest grounds select, top pulls write pin low,
  // middle leaves the pin to the pull-up [RULE6] [RULE7] [RULE8]
  assign bus.lowest_slice_select_n = (role_in != CSC_ROLE_LOW); // [RULE6]
  assign bus.wr_c_out = 1'b0; // [RULE8]
  assign bus.wr_c_oe = (role_in == CSC_ROLE_TOP); // [RULE8] [RULE7]
  // Write strobe taken from this slice's own write pin, which the lowest slice drives and the top strap pulls low
  assign bus.write_enable_n = bus.write_or_top_slice_pin; // [RULE6]

  // End-of-word shift multiplexer, chosen by microcode [RULE5]
  always_comb begin
    case (shift_sel_in)
      CSC_SH_ZERO: fill = 1'b0;
      CSC_SH_ONE: fill = 1'b1;
      CSC_SH_ROT: fill = bus.alu_shift_port_hi ^ bus.alu_shift_port_lo;
      CSC_SH_USER: fill = shift_user_in;
      default: fill = 1'b0;
    endcase
  end

  // Feed both ends; the slice's own drive wins where it drives
  assign bus.ql_c_out = fill; // [RULE5]
  assign bus.ql_c_oe = 1'b1;
  assign bus.qh_c_out = fill;
  assign bus.qh_c_oe = 1'b1;
  assign bus.sl_c_out = fill;
  assign bus.sl_c_oe = 1'b1;
  assign bus.sh_c_out = fill;
  assign bus.sh_c_oe = 1'b1;

  assign y_out = y_q;
  assign zero_out = zero_q; // [RULE9]

endmodule

// File: verif/csc_checker.sv
// Checker for the slice-to-controller connection
`include "csc_params.svh"
module csc_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Microinstruction and straps
  input wire logic [`CSC_IW-1:0] instr,
  input wire logic instruction_enable_low,
  input wire logic lowest_slice_select_n,
  // Results and shared lines
  input wire logic [`CSC_W-1:0] y,
  input wire logic carry_output,
  input wire logic gen_n_or_sign,
  input wire logic prop_n_or_overflow_flag,
  input wire logic write_or_top_slice_pin,
  input wire logic alu_shift_port_lo,
  input wire logic alu_shift_port_hi,
  input wire logic sl_s_oe,
  input wire logic zero_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ---------------------------------------------------------------
  // Decoded fields
  // ---------------------------------------------------------------
  logic [3:0] dst;
  logic [3:0] fn;
  logic is_top;
  logic is_logic;
  assign dst = instr[`CSC_DST_HI:`CSC_DST_LO];
  assign fn = instr[`CSC_FN_HI:`CSC_FN_LO];
  // Top slice is seen from its straps, not from the role flop
  assign is_top = lowest_slice_select_n && !write_or_top_slice_pin;
  assign is_logic = fn inside {`CSC_FN_AND, `CSC_FN_OR, `CSC_FN_XOR,
                               `CSC_FN_PASS};

  // Write cycle blocked by the enable, and a stored sign extension
  sequence s_blocked;
    !lowest_slice_select_n && instruction_enable_low;
  endsequence
  sequence s_ext_store;
    !lowest_slice_select_n && !instruction_enable_low && dst == 4'hE;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  parity_out_a: assert property (
    dst inside {[4'h4:4'h7]} |-> sl_s_oe &&
      alu_shift_port_lo == (^y ^ alu_shift_port_hi))
    else $error("parity on lower port wrong");
  sign_spread_a: assert property (
    dst == 4'hE |-> y == {4{alu_shift_port_lo}} &&
      alu_shift_port_hi == alu_shift_port_lo)
    else $error("sign extension not spread");
  msb_pass_a: assert property (
    dst == 4'hF |-> alu_shift_port_hi == y[3])
    else $error("result msb missing on upper port");
  top_sign_a: assert property (
    is_top && dst == 4'hF |-> gen_n_or_sign == y[3])
    else $error("top slice sign wrong");
  gp_logic_a: assert property (
    !is_top && is_logic |->
      gen_n_or_sign && prop_n_or_overflow_flag && !carry_output)
    else $error("generate or propagate wrong in logic mode");
  zero_wire_a: assert property (
    zero_line == (y == 4'h0))
    else $error("zero line disagrees with result");
  write_block_a: assert property (
    s_blocked |-> write_or_top_slice_pin)
    else $error("write strobe low while disabled");
  ext_store_a: assert property (
    s_ext_store |-> !write_or_top_slice_pin)
    else $error("sign extension not written");
  shift_down_a: assert property (
    dst == `CSC_DST_RAM_DN |-> y[3] == alu_shift_port_hi)
    else $error("shift down lost upper bit");
  shift_up_a: assert property (
    dst == `CSC_DST_RAM_UP |-> y[0] == alu_shift_port_lo)
    else $error("shift up lost lower bit");
endmodule

// File: verif/cpu_slice_cascade_logic_tb.sv
// Self-checking bench: one slice facing its controller
`include "csc_params.svh"
module cpu_slice_cascade_logic_tb import csc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [8:0] instr_in = `CSC_RST_INSTR;
  logic [3:0] a_addr_in = 4'h0, b_addr_in = 4'h0, data_in = 4'h0;
  logic iel_in = 1'b1, carry_input_in = 1'b0, shift_user_in = 1'b0;
  logic three_in = 1'b0;
  logic [3:0] c_addr_in = 4'h0;
  csc_role_t role_in = CSC_ROLE_LOW;
  csc_shsel_t shift_sel_in = CSC_SH_ZERO;
  logic [3:0] y_out, q_reg_out;
  logic zero_out;
  csc_role_t role_out;
  int n_errors = 0, tests_run = 0, cycles = 0;

  csc_if bus_if();
  // Controller end and slice end meet in one interface
  csc_ctrl i_csc_ctrl(.clk_in, .nrst_in, .instr_in, .a_addr_in,
    .b_addr_in, .c_addr_in, .three_addr_in(three_in), .data_in,
    .instruction_enable_low_in(iel_in), .carry_input_in, .role_in,
    .shift_sel_in, .shift_user_in, .y_out, .zero_out, .bus(bus_if));
  csc_slice i_csc_slice(.clk_in, .nrst_in, .bus(bus_if), .q_reg_out,
    .role_out);
  csc_checker i_csc_checker(.clk_in, .nrst_in, .instr(bus_if.instr),
    .instruction_enable_low(bus_if.instruction_enable_low),
    .lowest_slice_select_n(bus_if.lowest_slice_select_n), .y(bus_if.y),
    .carry_output(bus_if.carry_output),
    .gen_n_or_sign(bus_if.gen_n_or_sign),
    .prop_n_or_overflow_flag(bus_if.prop_n_or_overflow_flag),
    .write_or_top_slice_pin(bus_if.write_or_top_slice_pin),
    .alu_shift_port_lo(bus_if.alu_shift_port_lo),
    .alu_shift_port_hi(bus_if.alu_shift_port_hi),
    .sl_s_oe(bus_if.sl_s_oe), .zero_line(bus_if.zero_line));

  // Clock, and a ceiling so a hang still reaches the report
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk4(input string nm, input logic [3:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [8:0] mk(input logic [3:0] d, f, input logic s);
    return {d, f, s};
  endfunction
  // Fetch one word; the enable drops back high for the word behind it,
  // so the repeat of this word in the pipeline writes nothing
  task automatic exec(input logic [8:0] i, input logic [3:0] a, b, d,
                      input logic iel, cin);
    @(posedge clk_in);
    instr_in <= i;
    a_addr_in <= a;
    b_addr_in <= b;
    data_in <= d;
    iel_in <= iel;
    carry_input_in <= cin;
    @(posedge clk_in);
    iel_in <= 1'b1;
    #5;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_store();
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b1), 4'h0, 4'h3, 4'h9, 0, 0);
    chk4("pass y", 4'h9, bus_if.y);
    chk1("pass msb", 1'b1, bus_if.alu_shift_port_hi);
    chk1("write out", 1'b0, bus_if.write_or_top_slice_pin);
    @(posedge clk_in);
    #5;
    chk4("piped y", 4'h9, y_out);
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b0), 4'h0, 4'h3, 4'h0, 1, 0);
    chk4("ram b3", 4'h9, bus_if.y);
  endtask

  task automatic t_hold();
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b1), 4'h0, 4'h3, 4'h6, 1, 0);
    chk1("write held", 1'b1, bus_if.write_or_top_slice_pin);
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b0), 4'h0, 4'h3, 4'h0, 1, 0);
    chk4("ram kept", 4'h9, bus_if.y);
    exec(mk(`CSC_DST_LOAD_Q, `CSC_FN_PASS, 1'b1), 4'h0, 4'h0, 4'h5, 1, 0);
    @(posedge clk_in);
    #5;
    chk4("q kept", 4'h0, q_reg_out);
    exec(mk(`CSC_DST_LOAD_Q, `CSC_FN_PASS, 1'b1), 4'h0, 4'h0, 4'h6, 0, 0);
    @(posedge clk_in);
    #5;
    chk4("q load", 4'h6, q_reg_out);
  endtask

  // Both words shift by one place with ones fed in at the open end
  task automatic t_shift();
    @(posedge clk_in) shift_sel_in <= CSC_SH_ONE;
    exec(mk(`CSC_DST_RAM_DN, `CSC_FN_PASS, 1'b1), 4'h0, 4'h4, 4'hA, 0, 0);
    chk4("down y", 4'hD, bus_if.y);
    chk1("down out", 1'b0, bus_if.alu_shift_port_lo);
    @(posedge clk_in);
    #5;
    chk4("q down", 4'hB, q_reg_out);
    exec(mk(`CSC_DST_RAM_UP, `CSC_FN_PASS, 1'b1), 4'h0, 4'h4, 4'h5, 0, 0);
    chk4("up y", 4'hB, bus_if.y);
    chk1("up out", 1'b0, bus_if.alu_shift_port_hi);
    @(posedge clk_in);
    #5;
    chk4("q up", 4'h7, q_reg_out);
  endtask

  task automatic t_parity();
    logic [3:0] d;
    for (int k = 4; k < 8; k++) begin
      d = 4'(k * 3);
      @(posedge clk_in) shift_sel_in <= k[0] ? CSC_SH_ONE : CSC_SH_ZERO;
      exec(mk(k[3:0], `CSC_FN_PASS, 1'b1), 4'h0, 4'h5, d, 1, 0);
      chk1("parity", ^d ^ k[0], bus_if.alu_shift_port_lo);
    end
  endtask

  // A single slice always extends; passing its own msb is code F above
  task automatic t_sign();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_in) begin
        shift_sel_in <= CSC_SH_USER;
        shift_user_in <= v[0];
      end
      exec(mk(`CSC_DST_SIGNX, `CSC_FN_ADD, 1'b1), 4'h0, 4'h6, 4'h5, 0, 0);
      chk4("ext y", {4{v[0]}}, bus_if.y);
      chk1("ext out", v[0], bus_if.alu_shift_port_hi);
      exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b0), 4'h0, 4'h6, 4'h0, 1, 0);
      chk4("ext stored", {4{v[0]}}, bus_if.y);
    end
  endtask

  task automatic t_arith();
    exec(mk(`CSC_DST_PASS, `CSC_FN_ADD, 1'b1), 4'h3, 4'h7, 4'h7, 1, 1);
    chk4("sum", 4'h1, bus_if.y);
    chk1("carry", 1'b1, bus_if.carry_output);
    chk1("gen low", 1'b0, bus_if.gen_n_or_sign);
    chk1("prop low", 1'b0, bus_if.prop_n_or_overflow_flag);
    chk1("zero busy", 1'b0, bus_if.zero_line);
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b1), 4'h0, 4'h7, 4'h0, 1, 0);
    chk1("zero line", 1'b1, bus_if.zero_line);
    @(posedge clk_in);
    #5;
    chk1("zero out", 1'b1, zero_out);
  endtask

  // Result steered to C; the B register must stay untouched
  task automatic t_three();
    @(posedge clk_in) begin
      three_in <= 1'b1;
      c_addr_in <= 4'hB;
    end
    exec(mk(`CSC_DST_PASS, `CSC_FN_ADD, 1'b1), 4'h3, 4'h7, 4'h2, 0, 0);
    chk4("three sum", 4'hB, bus_if.y);
    @(posedge clk_in) three_in <= 1'b0;
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b0), 4'h0, 4'hB, 4'h0, 1, 0);
    chk4("three c", 4'hB, bus_if.y);
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b0), 4'h0, 4'h7, 4'h0, 1, 0);
    chk4("three b", 4'h0, bus_if.y);
  endtask

  task automatic t_roles();
    @(posedge clk_in) role_in <= CSC_ROLE_MID;
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b1), 4'h0, 4'h8, 4'h8, 0, 0);
    chk4("mid role", {1'b0, CSC_ROLE_MID}, {1'b0, role_out});
    chk1("mid pin", 1'b1, bus_if.write_or_top_slice_pin);
    @(posedge clk_in) role_in <= CSC_ROLE_TOP;
    exec(mk(`CSC_DST_PASS, `CSC_FN_PASS, 1'b1), 4'h0, 4'h8, 4'h8, 0, 0);
    chk4("top role", {1'b0, CSC_ROLE_TOP}, {1'b0, role_out});
    chk1("top pin", 1'b0, bus_if.write_or_top_slice_pin);
    chk1("top sign", 1'b1, bus_if.gen_n_or_sign);
    chk1("top ovr", 1'b0, bus_if.prop_n_or_overflow_flag);
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_store();
    t_hold();
    t_shift();
    t_parity();
    t_sign();
    t_arith();
    t_three();
    t_roles();
    summarize();
  end
endmodule
